//--- hdl/bir_regs.svh
// layout and reset constants for the board interrupt routing block
`ifndef BIR_REGS_SVH
`define BIR_REGS_SVH
`define BIR_NUM_INPUTS   8
`define BIR_IDX_W        3
`define BIR_MAX_CASCADE  64
`define BIR_VEC_BASE_RST 8'h20
`endif

//--- hdl/bir_pkg.sv
// types shared by the board interrupt routing block
package bir_pkg;
    typedef enum logic [1:0] {
        BIR_IDLE,
        BIR_PENDING,
        BIR_SERVICE
    } bir_state_t;
    typedef logic [2:0] bir_idx_t;
endpackage

//--- hdl/bir_prio_if.sv
// carrier between the controller and its priority resolver
`timescale 1ns/10ps
interface bir_prio_if;
    logic [7:0] req;
    logic       any;
    logic [2:0] idx;
    modport ctl (output req, input any, input idx);
    modport enc (input req, output any, output idx);
endinterface

//--- hdl/bir_prio_enc.sv
// fixed priority resolver, input zero highest
`timescale 1ns/10ps
module bir_prio_enc (
    bir_prio_if.enc p
);
    import bir_pkg::*;
    always_comb begin
        p.any = 1'b0;
        p.idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (p.req[i]) begin
                p.any = 1'b1;
                p.idx = i[2:0];
            end
        end
    end
endmodule

//--- hdl/bir_cascade_master.sv
// cascade master interrupt controller with processor request routing
// ============================================================
// Summary of operation
// - bus line zero highest, seven lowest
// - master input zero highest, seven lowest
// - non-maskable request outranks all, level+edge
// - per-input local or remote vectoring
// - eight direct inputs, 64 via slaves
// - request output drives processor directly
// - parallel bit drives active-low outbound request
// - sources active high, bus lines active low
// - remote input lets slave supply vector
`timescale 1ns/10ps
`include "bir_regs.svh"
module bir_cascade_master #(
    parameter int N = `BIR_NUM_INPUTS
) (
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic [N-1:0]         pic_request_input,
    input  wire logic [N-1:0]         bus_request_line_n,
    input  wire logic [N-1:0]         bus_route_sel,
    input  wire logic [N-1:0]         mask,
    input  wire logic [N-1:0]         remotely_vectored,
    input  wire logic [7:0]           vec_base,
    input  wire logic                 power_fail_request_n,
    input  wire logic                 inta,
    input  wire logic                 eoi,
    input  wire logic                 port_bit,
    output logic                      maskable_cpu_request,
    output logic                      nmi_req,
    output logic                      vec_valid,
    output logic [7:0]                vec_out,
    output logic                      slave_vec_en,
    output logic [2:0]                slave_sel,
    output logic                      outbound_bus_request_n,
    output logic [N-1:0]              in_service
);
    import bir_pkg::*;

    bir_prio_if  pif ();
    bir_state_t  state_r;
    logic [N-1:0] req_hi;
    logic [N-1:0] isr_r;
    logic [2:0]   cur_r;
    logic         pf_prev_r;

    // ============================================================
    // request conditioning
    // levels only: a source holds its line until acknowledged
    // bus lines inverted to active high
    // bus line k feeds input k, keeping order
    assign req_hi = (bus_route_sel & ~bus_request_line_n) | (~bus_route_sel & pic_request_input);
    // nothing new while one is in service
    assign pif.req = (state_r == BIR_IDLE) ? (req_hi & ~mask) : '0;

    bir_prio_enc u_enc (
        .p (pif)
    );

    // ============================================================
    // request state machine
    // resolver choice captured
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= BIR_IDLE;
            cur_r   <= 3'h0;
            isr_r   <= '0;
        end else begin
            unique case (state_r)
                BIR_IDLE: begin
                    if (pif.any) begin
                        state_r <= BIR_PENDING;
                        cur_r   <= pif.idx;
                    end
                end
                BIR_PENDING: begin
                    if (inta) begin
                        state_r      <= BIR_SERVICE;
                        isr_r[cur_r] <= 1'b1;
                    end
                end
                BIR_SERVICE: begin
                    // next request released at end of service
                    if (eoi) begin
                        state_r <= BIR_IDLE;
                        isr_r   <= '0;
                    end
                end
                // a stray code falls back to idle
                default: state_r <= BIR_IDLE;
            endcase
        end
    end

    // straight from state, no gating downstream
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) maskable_cpu_request <= 1'b0;
        else maskable_cpu_request <= (state_r == BIR_IDLE) ? pif.any : (state_r == BIR_PENDING && !inta);
    end

    // ============================================================
    // vector supply
    // local inputs answer with own vector
    // remote inputs hand the cycle to the slave
    // slave select plus slave index gives 64
    // vector is a one-cycle pulse; a remote slave owns the data then
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vec_valid    <= 1'b0;
            vec_out      <= 8'h00;
            slave_vec_en <= 1'b0;
            slave_sel    <= 3'h0;
        end else begin
            vec_valid    <= 1'b0;
            slave_vec_en <= 1'b0;
            if (state_r == BIR_PENDING && inta) begin
                slave_sel <= cur_r;
                if (remotely_vectored[cur_r]) slave_vec_en <= 1'b1;
                else begin
                    vec_valid <= 1'b1;
                    vec_out   <= vec_base + {5'h00, cur_r};
                end
            end
        end
    end

    // at most one bit is set, so eoi clears them all
    assign in_service = isr_r;

    // ============================================================
    // non-maskable path
    // level or falling edge, never masked
    // fed from the active-low power fail line
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_prev_r <= 1'b1;
            nmi_req   <= 1'b0;
        end else begin
            pf_prev_r <= power_fail_request_n;
            nmi_req   <= ~power_fail_request_n | (pf_prev_r & ~power_fail_request_n);
        end
    end

    // ============================================================
    // outbound bus request
    // parallel bit drives bus request
    // driven active low
    // registered so a port glitch never reaches the bus
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) outbound_bus_request_n <= 1'b1;
        else outbound_bus_request_n <= ~port_bit;
    end

    // ============================================================
    // checks
    a_nmi_follows_pf: assert property (@(posedge core_clk) disable iff (!arst_n)
        !power_fail_request_n |=> nmi_req)
        else $error("nmi not raised on power fail");
    a_outbound_low: assert property (@(posedge core_clk) disable iff (!arst_n)
        port_bit |=> !outbound_bus_request_n)
        else $error("outbound request not driven low");
    a_pick_highest: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_IDLE && pif.req[0]) |=> cur_r == 3'h0)
        else $error("input zero not chosen first");
    a_one_at_time: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_SERVICE && !eoi) |=> state_r == BIR_SERVICE)
        else $error("service left without end");
    a_local_vector: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta && !remotely_vectored[cur_r]) |=> vec_valid && !slave_vec_en)
        else $error("local vector missing");
    a_remote_vector: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta && remotely_vectored[cur_r]) |=> slave_vec_en && !vec_valid)
        else $error("slave not given the vector cycle");
    a_req_direct: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && !inta) |=> maskable_cpu_request)
        else $error("request output dropped while pending");
    a_bus_polarity: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_IDLE && bus_route_sel[0] && !bus_request_line_n[0] && !mask[0]) |=> maskable_cpu_request)
        else $error("low bus line not seen as request");

    // ============================================================
    // checks: nmi, outbound, vector, service, idle and request selection behaviour
    a_nmi_level_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        power_fail_request_n |=> !nmi_req)
        else $error("nmi held without power fail");
    a_outbound_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        !port_bit |=> outbound_bus_request_n)
        else $error("outbound request driven while port bit low");
    a_vector_value: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta && !remotely_vectored[cur_r]) |=>
            vec_out == $past(vec_base) + {5'h00, $past(cur_r)})
        else $error("local vector does not match base plus index");
    a_slave_index: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta) |=> slave_sel == $past(cur_r))
        else $error("slave select does not name the captured input");
    a_isr_marked: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta) |=> in_service[$past(cur_r)])
        else $error("in-service bit not set on acknowledge");
    a_eoi_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_SERVICE && eoi) |=> (state_r == BIR_IDLE && in_service == '0))
        else $error("end of service did not release the controller");
    a_ack_drops_req: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && inta) |=> !maskable_cpu_request)
        else $error("request output still high after acknowledge");
    a_quiet_service: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_SERVICE) |=> !maskable_cpu_request)
        else $error("request raised while one is in service");
    a_idle_no_req: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_IDLE && !pif.any) |=> (state_r == BIR_IDLE && !maskable_cpu_request))
        else $error("request raised with nothing pending");
    a_unselected_bus: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_IDLE && !bus_route_sel[0] && pic_request_input[0] && !mask[0]) |=> cur_r == 3'h0)
        else $error("high on-board source not taken as request");
    a_bus_low_picks: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_IDLE && !bus_request_line_n[1] && pif.req[1] && !pif.req[0]) |=> cur_r == 3'h1)
        else $error("bus line one not ranked next");
    a_pending_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_r == BIR_PENDING && !inta) |=> (state_r == BIR_PENDING && cur_r == $past(cur_r)))
        else $error("pending request lost before acknowledge");
    a_vec_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(state_r == BIR_PENDING && inta) |=> $stable(vec_out))
        else $error("vector changed outside an acknowledge");
endmodule

//--- bench/bir_host_model.sv
// processor model: acknowledges a request, then ends its service
`timescale 1ns/10ps
module bir_host_model (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic slow,
    input  wire logic maskable_cpu_request,
    input  wire logic vec_valid,
    input  wire logic slave_vec_en,
    output logic      inta,
    output logic      eoi
);
    logic       busy_r;
    logic [1:0] cnt_r;
    // ========
    // handshake
    // one ack per request, slow mode waits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            inta <= 1'b0;
            eoi <= 1'b0;
            busy_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            inta <= 1'b0;
            eoi <= 1'b0;
            if (!busy_r && maskable_cpu_request && (!slow || cnt_r == 2'h0)) begin
                inta <= 1'b1;
                busy_r <= 1'b1;
            end
            if (busy_r && (vec_valid || slave_vec_en)) begin
                eoi <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end
endmodule

//--- bench/tb_bir_cascade_master.sv
// testbench for the cascade master
`timescale 1ns/10ps
module tb_bir_cascade_master;
    logic core_clk = 0, arst_n = 0, pfr_n = 1, inta, eoi, port_bit = 0, slow = 0;
    logic [7:0] on = 0, bus_n = 8'hff, sel = 0, msk = 0, rv = 0, base = 8'h20;
    logic mreq, nmi, vv, sv, ob_n;
    logic [7:0] vo, isv;
    logic [2:0] ss;
    logic [31:0] s = 32'hd432;
    int bad_count = 0, n_compared = 0;
    bir_cascade_master bir_cascade_master_inst (.core_clk(core_clk), .arst_n(arst_n),
        .pic_request_input(on), .bus_request_line_n(bus_n), .bus_route_sel(sel), .mask(msk),
        .remotely_vectored(rv), .vec_base(base), .power_fail_request_n(pfr_n), .inta(inta),
        .eoi(eoi), .port_bit(port_bit), .maskable_cpu_request(mreq), .nmi_req(nmi),
        .vec_valid(vv), .vec_out(vo), .slave_vec_en(sv), .slave_sel(ss),
        .outbound_bus_request_n(ob_n), .in_service(isv));
    bir_host_model bir_host_model_inst (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
        .maskable_cpu_request(mreq), .vec_valid(vv), .slave_vec_en(sv), .inta(inta), .eoi(eoi));
    initial forever #10 core_clk = ~core_clk;
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [3:0] low(input logic [7:0] v);
        for (int i = 0; i < 8; i++) if (v[i]) return i[3:0];
        return 4'h8;
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========
    // one request round
    task run(input logic [7:0] a, b, c, m, r);
        logic [3:0] k;
        int n;
        @(posedge core_clk);
        {on, bus_n, sel, msk, rv} <= {a, b, c, m, r};
        k = low(((c & ~b) | (~c & a)) & ~m);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (vv !== 1 && sv !== 1 && n < 20);
        chk({7'h0, vv | sv}, {7'h0, k != 8});
        if (k != 8 && r[k[2:0]]) chk({sv, 4'h0, ss}, {5'h10, k[2:0]});
        else if (k != 8) chk(vo, base + k);
        if (k != 8) chk(isv, 8'h1 << k);
        @(posedge core_clk);
        {on, bus_n} <= {8'h0, 8'hff};
        repeat (5) @(posedge core_clk);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1;
        run(8'hff, 8'hff, 0, 0, 0);
        run(8'h80, 8'hff, 0, 0, 0);
        run(8'hff, 8'hff, 0, 8'hff, 0);
        run(0, 8'hf7, 8'hff, 0, 0);
        run(8'h40, 8'hff, 0, 0, 8'hff);
        for (int i = 0; i < 60; i++) begin
            s = lfsr(s);
            slow <= s[3];
            base <= s[31:24];
            run(s[7:0], s[15:8], s[23:16], s[7:0] & s[30:23], s[27:20]);
        end
        pfr_n <= 0;
        port_bit <= 1;
        repeat (2) @(posedge core_clk);
        #1 chk({nmi, ob_n}, 8'h2);
        @(posedge core_clk);
        arst_n <= 0;
        #1 chk({3'h0, mreq, nmi, vv, sv, ob_n}, 8'h01);
        chk(isv, 8'h00);
        repeat (4) @(posedge core_clk);
        arst_n <= 1;
        repeat (2) @(posedge core_clk);
        #1 chk({6'h0, nmi, ob_n}, 8'h2);
        @(posedge core_clk);
        {pfr_n, port_bit} <= 2'b10;
        repeat (2) @(posedge core_clk);
        #1 chk({6'h0, nmi, ob_n}, 8'h1);
        run(8'h0c, 8'hff, 0, 0, 8'h04);
        report_and_stop;
    end
endmodule
